/* File: hdl/tcc_pkg.sv */
// Purpose: constants and types shared by the 16-bit timer with input capture
// Assumes: apb slave, 32-bit data, each 8-bit register in the low byte of one word
package tcc_pkg;
  localparam logic [7:0] ADDR_CTRL_A = 8'h00;
  localparam logic [7:0] ADDR_CTRL_B = 8'h04;
  localparam logic [7:0] ADDR_CNT_LO = 8'h08;
  localparam logic [7:0] ADDR_CNT_HI = 8'h0C;
  localparam logic [7:0] ADDR_CMPA_LO = 8'h10;
  localparam logic [7:0] ADDR_CMPA_HI = 8'h14;
  localparam logic [7:0] ADDR_CMPB_LO = 8'h18;
  localparam logic [7:0] ADDR_CMPB_HI = 8'h1C;
  localparam logic [7:0] ADDR_CAP_LO = 8'h20;
  localparam logic [7:0] ADDR_CAP_HI = 8'h24;
  localparam logic [7:0] ADDR_FLAGS = 8'h28;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h2C;
  localparam logic [7:0] ADDR_CMP_CS = 8'h30;
  // flag and enable bit positions
  localparam int BIT_OVF = 0;
  localparam int BIT_CAP = 1;
  // comparator control bit positions
  localparam int BIT_CMP_SEL = 0;
  localparam int BIT_CMP_OUT = 1;
  // fixed top values
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  localparam logic [15:0] TOP_MAX = 16'hFFFF;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // prescaler tap masks: tick when all masked bits of the prescaler are set
  localparam logic [9:0] PRE_MASK_8 = 10'h007;
  localparam logic [9:0] PRE_MASK_64 = 10'h03F;
  localparam logic [9:0] PRE_MASK_256 = 10'h0FF;
  localparam logic [9:0] PRE_MASK_1024 = 10'h3FF;
  localparam int FILTER_SAMPLES = 4;

  typedef enum logic [2:0] {
    CS_STOP = 3'h0, CS_DIV1 = 3'h1, CS_DIV8 = 3'h2, CS_DIV64 = 3'h3,
    CS_DIV256 = 3'h4, CS_DIV1024 = 3'h5, CS_EXT_FALL = 3'h6, CS_EXT_RISE = 3'h7
  } tcc_clksel_e;

  typedef enum logic [1:0] {
    SEQ_NORMAL = 2'h0, SEQ_DUAL = 2'h1, SEQ_CTC = 2'h3, SEQ_FAST = 2'h2
  } tcc_seq_e;

  // timer_ctrl_b layout, msb first
  typedef struct packed {
    logic filter_en;
    logic edge_rise;
    logic spare;
    logic [1:0] wave_mode_hi;
    tcc_clksel_e clock_select;
  } tcc_ctrl_b_s;

  // timer_ctrl_a layout, msb first
  typedef struct packed {
    logic [5:0] spare;
    logic [1:0] wave_mode_lo;
  } tcc_ctrl_a_s;
endpackage : tcc_pkg

/* File: hdl/tcc_timer16.sv */
// Purpose: 16-bit up/down timer counter with input capture, apb register access
// Assumes: pclk 50 MHz; capture pin, comparator output and ext clock are asynchronous
// Notes: compare B is storage only, compare A also sets top in modes 4, 9, B and F; compare and waveform logic live elsewhere
//
// The address map and the APB interface to the registers are this design's own decisions.
module tcc_timer16 (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic capture_pin,
  input wire logic comparator_output,
  input wire logic ext_clock_pin,
  input wire logic ovf_irq_ack,
  input wire logic cap_irq_ack,
  output logic ovf_irq,
  output logic cap_irq,
  output logic at_top,
  output logic at_bottom,
  output logic [3:0] wave_mode,
  output logic [15:0] count_value,
  output logic [15:0] compare_a,
  output logic [15:0] compare_b
);
  tcc_pkg::tcc_ctrl_a_s ctrl_a_reg;
  tcc_pkg::tcc_ctrl_b_s ctrl_b_reg;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [15:0] cap_reg;
  logic [15:0] cmpa_reg;
  logic [15:0] cmpb_reg;
  logic [7:0] temp_reg;
  logic [7:0] snap_hi_reg;
  logic count_down_reg;
  logic ovf_flag_reg;
  logic cap_flag_reg;
  logic ovf_ie_reg;
  logic cap_ie_reg;
  logic cmp_sel_reg;
  logic [9:0] pre_reg;
  logic [2:0] ext_sync_reg;
  logic [1:0] pin_sync_reg;
  logic [1:0] cmp_sync_reg;
  logic [tcc_pkg::FILTER_SAMPLES-2:0] filt_shift_reg;
  logic filt_out_reg;
  logic edge_prev_reg;
  logic [3:0] mode;
  logic [15:0] top;
  tcc_pkg::tcc_seq_e seq;
  logic cap_is_top;
  logic tick;
  logic setup;
  logic done;
  logic wr;
  logic rd;
  logic [7:0] addr;
  logic [7:0] wbyte;
  logic mapped;
  logic [7:0] rbyte;
  logic [15:0] step_val;
  logic step_dir;
  logic ovf_set;
  logic cap_src;
  logic edge_in;
  logic capture;
  logic cpu_cnt_wr;

  assign addr = paddr[7:0];
  assign wbyte = pwdata[7:0];
  assign setup = psel & ~penable;
  assign done = psel & penable & pready & ~pslverr; // refused accesses change nothing
  assign wr = done & pwrite;
  assign rd = done & ~pwrite;
  assign mode = {ctrl_b_reg.wave_mode_hi, ctrl_a_reg.wave_mode_lo};
  assign cpu_cnt_wr = wr & (addr == tcc_pkg::ADDR_CNT_LO);

  // decode of the 16 wave modes into sequence kind and top value
  always_comb begin
    seq = tcc_pkg::SEQ_NORMAL;
    top = tcc_pkg::TOP_MAX;
    cap_is_top = 1'b0;
    unique case (mode)
      4'h1: begin seq = tcc_pkg::SEQ_DUAL; top = tcc_pkg::TOP_8BIT; end
      4'h2: begin seq = tcc_pkg::SEQ_DUAL; top = tcc_pkg::TOP_9BIT; end
      4'h3: begin seq = tcc_pkg::SEQ_DUAL; top = tcc_pkg::TOP_10BIT; end
      4'h4: begin seq = tcc_pkg::SEQ_CTC; top = cmpa_reg; end
      4'h5: begin seq = tcc_pkg::SEQ_FAST; top = tcc_pkg::TOP_8BIT; end
      4'h6: begin seq = tcc_pkg::SEQ_FAST; top = tcc_pkg::TOP_9BIT; end
      4'h7: begin seq = tcc_pkg::SEQ_FAST; top = tcc_pkg::TOP_10BIT; end
      4'h8: begin seq = tcc_pkg::SEQ_DUAL; top = cap_reg; cap_is_top = 1'b1; end
      4'h9: begin seq = tcc_pkg::SEQ_DUAL; top = cmpa_reg; end
      4'hA: begin seq = tcc_pkg::SEQ_DUAL; top = cap_reg; cap_is_top = 1'b1; end
      4'hB: begin seq = tcc_pkg::SEQ_DUAL; top = cmpa_reg; end
      4'hC: begin seq = tcc_pkg::SEQ_CTC; top = cap_reg; cap_is_top = 1'b1; end
      4'hE: begin seq = tcc_pkg::SEQ_FAST; top = cap_reg; cap_is_top = 1'b1; end
      4'hF: begin seq = tcc_pkg::SEQ_FAST; top = cmpa_reg; end
      default: begin seq = tcc_pkg::SEQ_NORMAL; top = tcc_pkg::TOP_MAX; end
    endcase
  end

  // prescaler runs freely so that a divided tick keeps a steady phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_reg <= 10'h000;
    end else begin
      pre_reg <= pre_reg + 10'h001;
    end
  end

  // ext clock pin: two stages of sync, third stage only for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_sync_reg <= 3'h0;
    end else begin
      ext_sync_reg <= {ext_sync_reg[1:0], ext_clock_pin};
    end
  end

  always_comb begin
    unique case (ctrl_b_reg.clock_select)
      tcc_pkg::CS_STOP: tick = 1'b0;
      tcc_pkg::CS_DIV1: tick = 1'b1;
      tcc_pkg::CS_DIV8: tick = &(pre_reg | ~tcc_pkg::PRE_MASK_8);
      tcc_pkg::CS_DIV64: tick = &(pre_reg | ~tcc_pkg::PRE_MASK_64);
      tcc_pkg::CS_DIV256: tick = &(pre_reg | ~tcc_pkg::PRE_MASK_256);
      tcc_pkg::CS_DIV1024: tick = &(pre_reg | ~tcc_pkg::PRE_MASK_1024);
      tcc_pkg::CS_EXT_FALL: tick = ext_sync_reg[2] & ~ext_sync_reg[1];
      tcc_pkg::CS_EXT_RISE: tick = ~ext_sync_reg[2] & ext_sync_reg[1];
    endcase
  end

  // one timer tick worth of counting, per sequence kind
  always_comb begin
    step_val = count_reg;
    step_dir = count_down_reg;
    ovf_set = 1'b0;
    unique case (seq)
      tcc_pkg::SEQ_DUAL: begin
        if (count_down_reg) begin
          if (count_reg == 16'h0000) begin
            step_dir = 1'b0;
            step_val = count_reg + 16'h0001;
          end else begin
            step_val = count_reg - 16'h0001;
            ovf_set = (count_reg == 16'h0001);
          end
        end else if (count_reg >= top) begin
          step_dir = 1'b1;
          step_val = count_reg - 16'h0001;
        end else begin
          step_val = count_reg + 16'h0001;
        end
      end
      tcc_pkg::SEQ_CTC: begin
        step_dir = 1'b0;
        step_val = (count_reg == top) ? 16'h0000 : count_reg + 16'h0001;
        ovf_set = (count_reg == tcc_pkg::TOP_MAX);
      end
      tcc_pkg::SEQ_FAST: begin
        step_dir = 1'b0;
        step_val = (count_reg == top) ? 16'h0000 : count_reg + 16'h0001;
        ovf_set = (count_reg == top);
      end
      tcc_pkg::SEQ_NORMAL: begin
        step_dir = 1'b0;
        step_val = count_reg + 16'h0001;
        ovf_set = (count_reg == tcc_pkg::TOP_MAX);
      end
    endcase
  end

  always_comb begin
    count_next = count_reg;
    if (cpu_cnt_wr) begin
      count_next = {temp_reg, wbyte};
    end else if (tick) begin
      count_next = step_val;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= 16'h0000;
      count_down_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      if (!cpu_cnt_wr && tick) begin
        count_down_reg <= step_dir;
      end
    end
  end

  // indications are registered from count_next, so they line up with count_value in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      at_top <= 1'b0;
      at_bottom <= 1'b0;
    end else begin
      at_top <= (count_next == top);
      at_bottom <= (count_next == 16'h0000);
    end
  end

  // capture inputs: two-stage synchronisers, same scheme as the ext clock pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sync_reg <= 2'h0;
      cmp_sync_reg <= 2'h0;
    end else begin
      pin_sync_reg <= {pin_sync_reg[0], capture_pin};
      cmp_sync_reg <= {cmp_sync_reg[0], comparator_output};
    end
  end

  assign cap_src = cmp_sel_reg ? cmp_sync_reg[1] : pin_sync_reg[1];

  // noise filter on the system clock, not the prescaled tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_shift_reg <= '0;
      filt_out_reg <= 1'b0;
    end else if (!cap_is_top) begin
      // the live sample is the fourth vote, so the filter costs exactly four cycles
      filt_shift_reg <= {filt_shift_reg[tcc_pkg::FILTER_SAMPLES-3:0], cap_src};
      if (&{filt_shift_reg, cap_src}) begin
        filt_out_reg <= 1'b1;
      end else if (~|{filt_shift_reg, cap_src}) begin
        filt_out_reg <= 1'b0;
      end
    end
  end

  assign edge_in = ctrl_b_reg.filter_en ? filt_out_reg : cap_src;
  assign capture = !cap_is_top && (ctrl_b_reg.edge_rise ?
                   (edge_in & ~edge_prev_reg) : (~edge_in & edge_prev_reg));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_prev_reg <= 1'b0;
    end else if (!cap_is_top) begin
      edge_prev_reg <= edge_in;
    end
  end

  // capture register: hardware copy wins; cpu may write it only as a top value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_reg <= 16'h0000;
    end else if (capture) begin
      cap_reg <= count_reg;
    end else if (wr && addr == tcc_pkg::ADDR_CAP_LO && cap_is_top) begin
      cap_reg <= {temp_reg, wbyte};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmpa_reg <= 16'h0000;
      cmpb_reg <= 16'h0000;
    end else if (wr) begin
      if (addr == tcc_pkg::ADDR_CMPA_LO) begin
        cmpa_reg <= {temp_reg, wbyte};
      end
      if (addr == tcc_pkg::ADDR_CMPB_LO) begin
        cmpb_reg <= {temp_reg, wbyte};
      end
    end
  end

  // shared high-byte latch: any high write fills it, a counter or capture low read loads it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      temp_reg <= 8'h00;
    end else if (wr && (addr == tcc_pkg::ADDR_CNT_HI || addr == tcc_pkg::ADDR_CMPA_HI ||
                        addr == tcc_pkg::ADDR_CMPB_HI || addr == tcc_pkg::ADDR_CAP_HI)) begin
      temp_reg <= wbyte;
    end else if (rd && (addr == tcc_pkg::ADDR_CNT_LO || addr == tcc_pkg::ADDR_CAP_LO)) begin
      temp_reg <= snap_hi_reg;
    end
  end

  // flags: a hardware set in the same cycle as a clear is kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_flag_reg <= 1'b0;
      cap_flag_reg <= 1'b0;
    end else begin
      if (tick && !cpu_cnt_wr && ovf_set) begin
        ovf_flag_reg <= 1'b1;
      end else if (ovf_irq_ack || (wr && addr == tcc_pkg::ADDR_FLAGS && wbyte[tcc_pkg::BIT_OVF])) begin
        ovf_flag_reg <= 1'b0;
      end
      if (capture) begin
        cap_flag_reg <= 1'b1;
      end else if (cap_irq_ack || (wr && addr == tcc_pkg::ADDR_FLAGS && wbyte[tcc_pkg::BIT_CAP])) begin
        cap_flag_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_irq <= 1'b0;
      cap_irq <= 1'b0;
    end else begin
      ovf_irq <= ovf_flag_reg & ovf_ie_reg;
      cap_irq <= cap_flag_reg & cap_ie_reg;
    end
  end

  // control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_a_reg <= tcc_pkg::CTRL_RESET;
      ctrl_b_reg <= tcc_pkg::CTRL_RESET;
      ovf_ie_reg <= 1'b0;
      cap_ie_reg <= 1'b0;
      cmp_sel_reg <= 1'b0;
    end else if (wr) begin
      if (addr == tcc_pkg::ADDR_CTRL_A) begin
        ctrl_a_reg <= wbyte;
      end
      if (addr == tcc_pkg::ADDR_CTRL_B) begin
        ctrl_b_reg <= wbyte;
      end
      if (addr == tcc_pkg::ADDR_IRQ_EN) begin
        ovf_ie_reg <= wbyte[tcc_pkg::BIT_OVF];
        cap_ie_reg <= wbyte[tcc_pkg::BIT_CAP];
      end
      if (addr == tcc_pkg::ADDR_CMP_CS) begin
        cmp_sel_reg <= wbyte[tcc_pkg::BIT_CMP_SEL];
      end
    end
  end

  // read mux; compare high bytes come straight from the register
  always_comb begin
    mapped = 1'b1;
    rbyte = 8'h00;
    unique case (addr)
      tcc_pkg::ADDR_CTRL_A: rbyte = ctrl_a_reg;
      tcc_pkg::ADDR_CTRL_B: rbyte = ctrl_b_reg;
      tcc_pkg::ADDR_CNT_LO: rbyte = count_reg[7:0];
      tcc_pkg::ADDR_CNT_HI: rbyte = temp_reg;
      tcc_pkg::ADDR_CMPA_LO: rbyte = cmpa_reg[7:0];
      tcc_pkg::ADDR_CMPA_HI: rbyte = cmpa_reg[15:8];
      tcc_pkg::ADDR_CMPB_LO: rbyte = cmpb_reg[7:0];
      tcc_pkg::ADDR_CMPB_HI: rbyte = cmpb_reg[15:8];
      tcc_pkg::ADDR_CAP_LO: rbyte = cap_reg[7:0];
      tcc_pkg::ADDR_CAP_HI: rbyte = temp_reg;
      tcc_pkg::ADDR_FLAGS: begin
        rbyte[tcc_pkg::BIT_OVF] = ovf_flag_reg;
        rbyte[tcc_pkg::BIT_CAP] = cap_flag_reg;
      end
      tcc_pkg::ADDR_IRQ_EN: begin
        rbyte[tcc_pkg::BIT_OVF] = ovf_ie_reg;
        rbyte[tcc_pkg::BIT_CAP] = cap_ie_reg;
      end
      tcc_pkg::ADDR_CMP_CS: begin
        rbyte[tcc_pkg::BIT_CMP_SEL] = cmp_sel_reg;
        rbyte[tcc_pkg::BIT_CMP_OUT] = cmp_sync_reg[1];
      end
      default: mapped = 1'b0;
    endcase
    if (paddr[31:8] != 24'h000000) begin
      mapped = 1'b0;
    end
  end

  // apb slave: one wait-free access phase; data and high-byte snapshot taken in setup
  // so the latched high byte always matches the low byte returned
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      snap_hi_reg <= 8'h00;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      if (setup) begin
        prdata <= (mapped && !pwrite) ? {24'h000000, rbyte} : 32'h0000_0000;
        snap_hi_reg <= (addr == tcc_pkg::ADDR_CAP_LO) ? cap_reg[15:8] : count_reg[15:8];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wave_mode <= 4'h0;
      count_value <= 16'h0000;
      compare_a <= 16'h0000;
      compare_b <= 16'h0000;
    end else begin
      wave_mode <= mode;
      count_value <= count_next;
      compare_a <= cmpa_reg;
      compare_b <= cmpb_reg;
    end
  end
endmodule : tcc_timer16

/* File: tb/tcc_event_src.sv */
// Purpose: far-side model driving the capture pin, comparator output and external clock
// Assumes: lines change by nonblocking assignment just after a rising pclk edge
// Notes: external clock runs free, one rising and one falling edge per eight pclk cycles
module tcc_event_src (
  input wire logic pclk,
  output logic capture_pin,
  output logic comparator_output,
  output logic ext_clock_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] div_reg = 3'h0;
  initial begin
    capture_pin = 1'b0;
    comparator_output = 1'b0;
  end
  always @(posedge pclk) begin
    div_reg <= div_reg + 3'h1;
  end
  assign ext_clock_pin = div_reg[2];
  // levels are held until the next call, like a port bit under software control
  task automatic drive(input logic pin, input logic cmp);
    capture_pin <= pin;
    comparator_output <= cmp;
  endtask : drive
endmodule : tcc_event_src

/* File: tb/tcc_timer16_properties.sv */
// Purpose: concurrent checks on the timer ports
// Assumes: one pclk domain, presetn asynchronous active low
// Notes: latch copy only tracks cpu writes; a counter or capture low-byte read makes it unknown
module tcc_timer16_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic cap_irq_ack,
  input wire logic cap_irq,
  input wire logic at_top,
  input wire logic at_bottom,
  input wire logic [3:0] wave_mode,
  input wire logic [15:0] count_value,
  input wire logic [15:0] compare_a
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic acc;
  logic wr_lo;
  logic [7:0] tmp_reg;
  logic tmp_ok_reg;
  logic [2:0] cs_reg;
  logic [15:0] exp_w;
  assign acc = psel && penable && pready;
  assign wr_lo = acc && pwrite && paddr[7:0] == tcc_pkg::ADDR_CNT_LO;
  assign exp_w = {tmp_reg, pwdata[7:0]};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmp_reg <= 8'h00;
      tmp_ok_reg <= 1'b0;
    end else if (acc && pwrite && paddr[7:0] inside {tcc_pkg::ADDR_CNT_HI,
        tcc_pkg::ADDR_CMPA_HI, tcc_pkg::ADDR_CMPB_HI, tcc_pkg::ADDR_CAP_HI}) begin
      tmp_reg <= pwdata[7:0];
      tmp_ok_reg <= 1'b1;
    end else if (acc && !pwrite && paddr[7:0] inside {tcc_pkg::ADDR_CNT_LO,
        tcc_pkg::ADDR_CAP_LO}) begin
      tmp_ok_reg <= 1'b0;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_reg <= 3'h0;
    end else if (acc && pwrite && paddr[7:0] == tcc_pkg::ADDR_CTRL_B) begin
      cs_reg <= pwdata[2:0];
    end
  end
  sequence cnt_write_s;
    wr_lo && tmp_ok_reg;
  endsequence
  sequence cnt_loaded_s;
    count_value == $past(exp_w);
  endsequence
  count_write_a: assert property (cnt_write_s |=> cnt_loaded_s)
    else $error("count write lost");
  step_one_a: assert property ($changed(count_value) && !$past(wr_lo) |->
    count_value == $past(count_value) + 16'h0001 ||
    count_value == $past(count_value) - 16'h0001 || count_value == 16'h0000)
    else $error("count moved by more than one");
  // three cycles of stop so a tick already in flight is not blamed
  stop_hold_a: assert property ((cs_reg == 3'h0) [*3] ##0 !wr_lo |=>
    $stable(count_value)) else $error("count moved while stopped");
  bottom_flag_a: assert property ($past(presetn) |->
    at_bottom == (count_value == 16'h0000)) else $error("bottom wrong");
  top_8bit_a: assert property (wave_mode inside {4'h1, 4'h5} &&
    count_value == tcc_pkg::TOP_8BIT |-> at_top) else $error("top missed");
  cap_ack_a: assert property (cap_irq_ack |-> ##2 !cap_irq)
    else $error("capture request not cleared");
  compare_copy_a: assert property (acc && pwrite && tmp_ok_reg &&
    paddr[7:0] == tcc_pkg::ADDR_CMPA_LO |-> ##2 compare_a == $past(exp_w, 2))
    else $error("compare a not loaded");
  mode_out_a: assert property (acc && pwrite && paddr[7:0] == tcc_pkg::ADDR_CTRL_A |->
    ##2 wave_mode[1:0] == $past(pwdata[1:0], 2)) else $error("wave mode wrong");
endmodule : tcc_timer16_properties

bind tcc_timer16 tcc_timer16_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .cap_irq_ack, .cap_irq, .at_top, .at_bottom, .wave_mode,
  .count_value, .compare_a);

/* File: tb/test_tcc_timer16.sv */
// Purpose: self-checking bench for the 16-bit timer with input capture
// Assumes: apb master tasks; event source model drives the capture inputs
// Notes: counter is stopped during capture work so captured values are exact
module test_tcc_timer16;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic ovf_irq_ack = 1'b0;
  logic cap_irq_ack = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, ovf_irq, cap_irq, at_top, at_bottom;
  logic capture_pin, comparator_output, ext_clock_pin;
  logic [3:0] wave_mode;
  logic [15:0] count_value, compare_a, compare_b;
  logic [2:0] ev;
  logic [7:0] rdat;
  logic rerr;
  int num_errors = 0;
  int comparisons = 0;
  int lat0, lat1;
  // last two entries select the partner's external clock, one edge per eight cycles
  int div[7] = '{1, 8, 64, 256, 1024, 8, 8};
  assign ev = {cap_irq, at_top, ovf_irq};
  always #10 pclk = ~pclk;
  tcc_timer16 DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .capture_pin, .comparator_output, .ext_clock_pin, .ovf_irq_ack,
    .cap_irq_ack, .ovf_irq, .cap_irq, .at_top, .at_bottom, .wave_mode, .count_value,
    .compare_a, .compare_b);
  tcc_event_src SRC (.pclk, .capture_pin, .comparator_output, .ext_clock_pin);
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // called just after a rising edge; request held until pready is sampled high
  task automatic apb(input logic wr_en, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr_en;
    paddr <= {24'h000000, a};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rdat = prdata[7:0];
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      num_errors++;
      stop_test();
    end
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk({8'h00, rdat}, {8'h00, e});
  endtask : rd
  task automatic wait_hi(input int k, output int c);
    c = 0;
    while (ev[k] !== 1'b1 && c < 300) begin
      @(posedge pclk);
      c++;
    end
    if (ev[k] !== 1'b1) begin
      num_errors++;
      stop_test();
    end
  endtask : wait_hi
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(tcc_pkg::ADDR_CTRL_B, 8'h00);
    apb(1'b0, 8'h3C, 8'h00);
    chk({15'h0000, rerr}, 16'h0001);
    wr(tcc_pkg::ADDR_CTRL_A, 8'h01);
    wr(tcc_pkg::ADDR_CTRL_B, 8'h08);
    @(posedge pclk);
    chk({12'h000, wave_mode}, 16'h0005);
    wr(tcc_pkg::ADDR_CTRL_A, 8'h00);
    foreach (div[i]) begin
      wr(tcc_pkg::ADDR_CNT_HI, 8'h00);
      wr(tcc_pkg::ADDR_CNT_LO, 8'h00);
      wr(tcc_pkg::ADDR_CTRL_B, 8'(i + 1));
      repeat (2048) @(posedge pclk);
      wr(tcc_pkg::ADDR_CTRL_B, 8'h00);
      chk({15'h0000, count_value >= 16'(2040 / div[i]) &&
        count_value <= 16'(2060 / div[i] + 1)}, 16'h0001);
    end
    $display("test clock select done");
    wr(tcc_pkg::ADDR_CNT_HI, 8'h12);
    wr(tcc_pkg::ADDR_CNT_LO, 8'h34);
    repeat (8) @(posedge pclk);
    chk(count_value, 16'h1234);
    rd(tcc_pkg::ADDR_CNT_LO, 8'h34);
    rd(tcc_pkg::ADDR_CNT_HI, 8'h12);
    wr(tcc_pkg::ADDR_CMPA_HI, 8'h56);
    wr(tcc_pkg::ADDR_CMPA_LO, 8'h78);
    wr(tcc_pkg::ADDR_CMPB_LO, 8'h9A);
    rd(tcc_pkg::ADDR_CNT_HI, 8'h56);
    rd(tcc_pkg::ADDR_CNT_LO, 8'h34);
    rd(tcc_pkg::ADDR_CMPB_HI, 8'h56);
    chk(compare_b, 16'h569A);
    $display("test 16-bit access done");
    wr(tcc_pkg::ADDR_CTRL_A, 8'h01);
    wr(tcc_pkg::ADDR_CNT_HI, 8'h00);
    wr(tcc_pkg::ADDR_CNT_LO, 8'hF0);
    wr(tcc_pkg::ADDR_FLAGS, 8'h03);
    wr(tcc_pkg::ADDR_IRQ_EN, 8'h01);
    wr(tcc_pkg::ADDR_CTRL_B, 8'h09);
    wait_hi(0, lat0);
    chk({8'h00, count_value[15:8]}, 16'h0000);
    ovf_irq_ack <= 1'b1;
    @(posedge pclk);
    ovf_irq_ack <= 1'b0;
    rd(tcc_pkg::ADDR_FLAGS, 8'h00);
    wr(tcc_pkg::ADDR_CTRL_B, 8'h01);
    wr(tcc_pkg::ADDR_CNT_LO, 8'hF0);
    repeat (2) @(posedge pclk);
    wait_hi(1, lat0);
    repeat (4) @(posedge pclk);
    chk({15'h0000, count_value < 16'h00FF && count_value > 16'h00F8}, 16'h0001);
    wr(tcc_pkg::ADDR_CTRL_B, 8'h00);
    $display("test counting done");
    wr(tcc_pkg::ADDR_CTRL_A, 8'h00);
    wr(tcc_pkg::ADDR_CTRL_B, 8'h40);
    wr(tcc_pkg::ADDR_IRQ_EN, 8'h02);
    wr(tcc_pkg::ADDR_FLAGS, 8'h03);
    wr(tcc_pkg::ADDR_CNT_HI, 8'h01);
    wr(tcc_pkg::ADDR_CNT_LO, 8'h00);
    SRC.drive(1'b1, 1'b0);
    wait_hi(2, lat0);
    rd(tcc_pkg::ADDR_FLAGS, 8'h02);
    cap_irq_ack <= 1'b1;
    @(posedge pclk);
    cap_irq_ack <= 1'b0;
    rd(tcc_pkg::ADDR_FLAGS, 8'h00);
    wr(tcc_pkg::ADDR_CNT_HI, 8'h02);
    wr(tcc_pkg::ADDR_CNT_LO, 8'h00);
    SRC.drive(1'b0, 1'b0);
    repeat (10) @(posedge pclk);
    rd(tcc_pkg::ADDR_FLAGS, 8'h00);
    rd(tcc_pkg::ADDR_CAP_LO, 8'h00);
    rd(tcc_pkg::ADDR_CAP_HI, 8'h01);
    wr(tcc_pkg::ADDR_CNT_HI, 8'h03);
    wr(tcc_pkg::ADDR_CNT_LO, 8'h00);
    SRC.drive(1'b1, 1'b0);
    wait_hi(2, lat0);
    wr(tcc_pkg::ADDR_FLAGS, 8'h02);
    wr(tcc_pkg::ADDR_CNT_HI, 8'h04);
    wr(tcc_pkg::ADDR_CNT_LO, 8'h00);
    wr(tcc_pkg::ADDR_CTRL_B, 8'hC0);
    SRC.drive(1'b0, 1'b0);
    repeat (12) @(posedge pclk);
    SRC.drive(1'b1, 1'b0);
    wait_hi(2, lat1);
    chk(16'(lat1 - lat0), 16'h0004);
    rd(tcc_pkg::ADDR_CAP_LO, 8'h00);
    rd(tcc_pkg::ADDR_CAP_HI, 8'h04);
    wr(tcc_pkg::ADDR_CTRL_B, 8'h80);
    wr(tcc_pkg::ADDR_FLAGS, 8'h02);
    SRC.drive(1'b0, 1'b0);
    repeat (3) @(posedge pclk);
    SRC.drive(1'b1, 1'b0);
    repeat (12) @(posedge pclk);
    rd(tcc_pkg::ADDR_FLAGS, 8'h00);
    $display("test capture pin done");
    wr(tcc_pkg::ADDR_CNT_HI, 8'h05);
    wr(tcc_pkg::ADDR_CNT_LO, 8'h00);
    wr(tcc_pkg::ADDR_CTRL_B, 8'h40);
    wr(tcc_pkg::ADDR_CMP_CS, 8'h01);
    wr(tcc_pkg::ADDR_FLAGS, 8'h02);
    SRC.drive(1'b1, 1'b1);
    wait_hi(2, lat0);
    rd(tcc_pkg::ADDR_CMP_CS, 8'h03);
    rd(tcc_pkg::ADDR_CAP_LO, 8'h00);
    rd(tcc_pkg::ADDR_CAP_HI, 8'h05);
    wr(tcc_pkg::ADDR_CAP_HI, 8'h77);
    wr(tcc_pkg::ADDR_CAP_LO, 8'h66);
    rd(tcc_pkg::ADDR_CAP_LO, 8'h00);
    rd(tcc_pkg::ADDR_CAP_HI, 8'h05);
    wr(tcc_pkg::ADDR_CTRL_B, 8'h58);
    wr(tcc_pkg::ADDR_CAP_HI, 8'h77);
    wr(tcc_pkg::ADDR_CAP_LO, 8'h66);
    rd(tcc_pkg::ADDR_CAP_LO, 8'h66);
    rd(tcc_pkg::ADDR_CAP_HI, 8'h77);
    wr(tcc_pkg::ADDR_FLAGS, 8'h02);
    SRC.drive(1'b1, 1'b0);
    repeat (6) @(posedge pclk);
    SRC.drive(1'b1, 1'b1);
    repeat (12) @(posedge pclk);
    rd(tcc_pkg::ADDR_FLAGS, 8'h00);
    $display("test comparator and top modes done");
    stop_test();
  end
endmodule : test_tcc_timer16
